/* dv/adcfmt_top_tb.sv */
module adcfmt_top_tb
  import adcfmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Stimulus and observation signals.
  // ************************************************************
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [31:0]        adr = '0, wdat = '0, rdat;
  logic               ack, sup_ok = 1'b1, ref_ok = 1'b1, msk = 1'b0;
  logic signed [11:0] meas = '0;
  logic               en_o, sw_o, gs_o, sc_o, irq, sc_q = 1'b0;
  logic [1:0]         refsel;
  logic [5:0]         chan;
  int                 fail_count = 0, compares = 0;
  int                 sw_cnt = 0, sw_len = 0, gs_cnt = 0, gs_len = 0, tg_cnt = 0, tg_gap = 0;

  adcfmt_top adcfmt_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .analog_supply_ok_i(sup_ok), .reference_ok_i(ref_ok), .meas_i(meas),
    .converter_enable_o(en_o), .sample_switch_o(sw_o), .gain_sample_o(gs_o),
    .secondary_conv_clock_o(sc_o), .reference_select_field_o(refsel), .channel_o(chan),
    .irq_o(irq));

  // The 25 MHz clock.
  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // ************************************************************
  // Pulse-width monitors: the last high pulse of both switch outputs, and the spacing of secondary clock edges.
  // ************************************************************
  always @(posedge clk_i) begin
    sc_q <= sc_o;
    if (sw_o) begin
      sw_cnt <= sw_cnt + 1;
    end else if (sw_cnt != 0) begin
      sw_len <= sw_cnt;
      sw_cnt <= 0;
    end
    if (gs_o) begin
      gs_cnt <= gs_cnt + 1;
    end else if (gs_cnt != 0) begin
      gs_len <= gs_cnt;
      gs_cnt <= 0;
    end
    // Spacing of the secondary clock edges, one less edge of latency.
    if (sc_q != sc_o) begin
      tg_gap <= tg_cnt;
      tg_cnt <= 1;
    end else begin
      tg_cnt <= tg_cnt + 1;
    end
  end

  // Compare and report at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One classic Wishbone cycle; the request holds until ack is sampled.
  task automatic wbx(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {27'h0, a};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    // A slave that never answers counts as a mismatch.
    if (ack !== 1'b1) begin
      chk({31'h0, ack}, 32'h1);
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wbx

  // Expected result code, clamped to the range of the mode.
  function automatic logic [9:0] code(input logic signed [11:0] m, input logic d);
    if (d) return (m > 511) ? 10'h1ff : (m < -512) ? 10'h200 : m[9:0];
    return (m > 1023) ? 10'h3ff : (m < 0) ? 10'h000 : m[9:0];
  endfunction : code

  // One full conversion with checks of result, flags and phase timing.
  task automatic conv(input logic signed [11:0] m, input logic dif, input logic la,
                      input logic [1:0] tt);
    logic [31:0] rd, lo;
    logic [9:0]  r;
    int          n;
    r = code(m, dif);
    wbx(1'b1, ADCFMT_OFS_CTRL_B, {4'h0, dif, 3'h0}, rd);
    wbx(1'b1, ADCFMT_OFS_CHREF, {2'h3, la, dif ? 5'h09 : 5'h02}, rd);
    wbx(1'b1, ADCFMT_OFS_CTRL_C, {6'h0, tt}, rd);
    meas <= m;
    wbx(1'b1, ADCFMT_OFS_CTRL_A, 8'hc4, rd);
    n = 0;
    do begin
      wbx(1'b0, ADCFMT_OFS_CTRL_A, 8'h0, rd);
      n++;
    end while (rd[6] && n < 400);
    chk(rd, 32'h84);
    chk({26'h0, chan}, {26'h0, dif, dif ? 5'h09 : 5'h02});
    chk({30'h0, refsel}, 32'h3);
    wbx(1'b0, ADCFMT_OFS_RES_LO, 8'h0, lo);
    wbx(1'b0, ADCFMT_OFS_RES_HI, 8'h0, rd);
    // Both alignments of the pair, read low byte first to lock it.
    if (la) chk({lo[7:0], rd[7:0]}, {r[1:0], 6'h0, r[9:2]});
    else chk({lo[7:0], rd[7:0]}, {r[7:0], 6'h0, r[9:8]});
    if (dif) chk({31'h0, rd[la ? 7 : 1]}, {31'h0, m < 0});
    wbx(1'b0, ADCFMT_OFS_IRQ_ST, 8'h0, rd);
    chk(rd, 32'h1);
    chk({31'h0, irq}, {31'h0, msk});
    wbx(1'b1, ADCFMT_OFS_IRQ_ST, 8'h1, rd);
    wbx(1'b0, ADCFMT_OFS_IRQ_ST, 8'h0, rd);
    chk({30'h0, irq, rd[0]}, 32'h0);
    if (dif) chk(gs_len, 16);
    else chk(32'(sw_len >= 13 && sw_len >= 16 * (tt + 1)), 32'h1);
    chk(tg_gap, 16);
  endtask : conv

  // Verdict and end of run.
  task automatic end_of_test();
    if (fail_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  // Watchdog: the planned sequence needs well under 40000 cycles.
  initial begin
    #(40 * 60000);
    fail_count++;
    end_of_test();
  end

  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    logic [31:0]        rd;
    logic signed [11:0] se[6], df[6];
    int                 n;
    se = '{12'sd2000, -12'sd5, 12'sd1023, 12'sd0, 12'sd1, 12'sd512};
    df = '{-12'sd600, 12'sd700, -12'sd1, 12'sd511, -12'sd512, -12'sd400};
    void'($urandom(20169));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wbx(1'b0, ADCFMT_OFS_CTRL_C, 8'h0, rd);
    chk(rd, 32'h0);
    wbx(1'b0, 5'h03, 8'h0, rd);
    chk(rd, 32'h0);
    // Start held off while the supply is not ready.
    sup_ok <= 1'b0;
    wbx(1'b1, ADCFMT_OFS_CTRL_A, 8'hc4, rd);
    repeat (300) @(posedge clk_i);
    wbx(1'b0, ADCFMT_OFS_CTRL_A, 8'h0, rd);
    chk({rd[6], en_o, sw_o}, 32'h6);
    sup_ok <= 1'b1;
    conv(12'sd100, 1'b0, 1'b0, 2'h0);
    msk = 1'b1;
    wbx(1'b1, ADCFMT_OFS_IRQ_MSK, 8'h1, rd);
    for (int i = 0; i < 6; i++) begin
      conv(se[i], 1'b0, i[0], 2'($urandom_range(3)));
      conv(df[i], 1'b1, i[1], 2'h0);
      conv(12'($urandom_range(1400)) - 12'sd200, 1'b0, 1'($urandom), 2'($urandom));
      conv(12'($urandom_range(1400)) - 12'sd700, 1'b1, 1'($urandom), 2'h0);
    end
    // Start-up of 10 units is 40 conversion clocks of 16 cycles before tracking begins.
    wbx(1'b1, ADCFMT_OFS_CTRL_A, 8'h04, rd);
    wbx(1'b1, ADCFMT_OFS_CTRL_C, 8'h28, rd);
    wbx(1'b1, ADCFMT_OFS_CTRL_A, 8'hc4, rd);
    n = 0;
    while (!(sw_o | gs_o) && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n >= 39 * 16 && n <= 41 * 16), 32'h1);
    end_of_test();
  end
endmodule : adcfmt_top_tb

/* rtl/adcfmt_pkg.sv */
package adcfmt_pkg;

  // ************************************************************
  // Register byte offsets on the Wishbone bus.
  // ************************************************************
  localparam logic [4:0] ADCFMT_OFS_CTRL_A  = 5'h00; // Enable, start, prescaler.
  localparam logic [4:0] ADCFMT_OFS_CTRL_B  = 5'h04; // Ready flags, channel extension.
  localparam logic [4:0] ADCFMT_OFS_CTRL_C  = 5'h08; // Start-up and tracking time.
  localparam logic [4:0] ADCFMT_OFS_CHREF   = 5'h0c; // Reference, adjust, channel.
  localparam logic [4:0] ADCFMT_OFS_RES_LO  = 5'h10; // Result low byte.
  localparam logic [4:0] ADCFMT_OFS_RES_HI  = 5'h14; // Result high byte.
  localparam logic [4:0] ADCFMT_OFS_IRQ_ST  = 5'h18; // Sticky event status.
  localparam logic [4:0] ADCFMT_OFS_IRQ_MSK = 5'h1c; // Event mask.

  // ************************************************************
  // Field positions inside the 8-bit registers.
  // ************************************************************
  localparam int ADCFMT_CA_EN      = 7;
  localparam int ADCFMT_CA_START   = 6;
  localparam int ADCFMT_CA_PRE_LSB = 0; // Three bits.
  localparam int ADCFMT_CB_SUP_OK  = 7;
  localparam int ADCFMT_CB_REF_OK  = 5;
  localparam int ADCFMT_CB_EXT     = 3;
  localparam int ADCFMT_CC_SUT_LSB = 2; // Five bits.
  localparam int ADCFMT_CC_TTH_LSB = 0; // Two bits.
  localparam int ADCFMT_CR_REF_LSB = 6; // Two bits.
  localparam int ADCFMT_CR_LADJ    = 5;
  localparam int ADCFMT_CR_CH_LSB  = 0; // Five bits.
  localparam int ADCFMT_ST_DONE    = 0;

  // ************************************************************
  // Values after reset.
  // ************************************************************
  localparam logic [2:0] ADCFMT_RST_PRE  = 3'h0;
  localparam logic [4:0] ADCFMT_RST_SUT  = 5'h00;
  localparam logic [1:0] ADCFMT_RST_TTH  = 2'h0;
  localparam logic [1:0] ADCFMT_RST_REF  = 2'h0;
  localparam logic [4:0] ADCFMT_RST_CH   = 5'h00;
  localparam logic       ADCFMT_RST_MASK = 1'b0;

  // ************************************************************
  // Timing constants.
  // ************************************************************
  localparam int unsigned ADCFMT_CLK_KHZ      = 25000;
  localparam int unsigned ADCFMT_MIN_TRACK_NS = 500;
  // Least time, so round up to whole cycles.
  localparam int unsigned ADCFMT_MIN_TRACK_CYC =
    (ADCFMT_MIN_TRACK_NS * ADCFMT_CLK_KHZ + 999999) / 1000000;
  localparam logic [7:0] ADCFMT_MIN_TRACK = 8'(ADCFMT_MIN_TRACK_CYC);
  localparam logic [7:0] ADCFMT_CONV_TICKS = 8'h0a; // Conversion clocks per result.
  localparam logic [1:0] ADCFMT_SUT_SHIFT  = 2'h2;  // Four clocks per start-up unit.
  localparam logic [4:0] ADCFMT_DIFF_CH    = 5'h08; // Low codes from here are differential.

  // ************************************************************
  // Sequencer states.
  // ************************************************************
  typedef enum logic [2:0] {
    ADCFMT_OFF     = 3'b000,
    ADCFMT_STARTUP = 3'b001,
    ADCFMT_READY   = 3'b010,
    ADCFMT_TRACK   = 3'b011,
    ADCFMT_CONVERT = 3'b100
  } adcfmt_state_t;

endpackage : adcfmt_pkg

/* rtl/adcfmt_sync2.sv */
// ************************************************************
// Two-flop synchroniser for asynchronous level inputs.
// ************************************************************
module adcfmt_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // The first stage feeds only the second, never any logic.
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } adcfmt_sync_t;

  adcfmt_sync_t s_r;   // Registered state.
  adcfmt_sync_t s_nxt; // Next state.

  // Shift the input through both stages.
  always_comb begin
    s_nxt        = s_r;
    s_nxt.meta   = d_i;
    s_nxt.stable = s_r.meta;
  end

  // Register with a synchronous clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q_o = s_r.stable;

endmodule : adcfmt_sync2

/* rtl/adcfmt_top.sv */
// Implementation choices: the placing of the registers and the Wishbone slave port.
module adcfmt_top
  import adcfmt_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [31:0]        wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               analog_supply_ok_i,
  input  wire logic               reference_ok_i,
  input  wire logic signed [11:0] meas_i,
  output logic                    converter_enable_o,
  output logic                    sample_switch_o,
  output logic                    gain_sample_o,
  output logic                    secondary_conv_clock_o,
  output logic      [1:0]         reference_select_field_o,
  output logic      [5:0]         channel_o,
  output logic                    irq_o
);

  // ************************************************************
  // Module state.
  // ************************************************************
  typedef struct packed {
    adcfmt_state_t state;
    logic [6:0]    pre_cnt;   // Prescaler phase.
    logic          sec_clk;   // Secondary conversion clock.
    logic [7:0]    tick_cnt;  // Conversion clocks in the current phase.
    logic [7:0]    min_cnt;   // System cycles spent tracking.
    logic          sample_sw; // Input sampling switch.
    logic          gain_s;    // Gain stage sampling.
    logic          ack;
    logic [31:0]   dat;
    logic          irq;
    logic          enable;    // Converter enable.
    logic          start;     // Start request, busy while set.
    logic [2:0]    presc;     // Prescaler field.
    logic [4:0]    sut;       // Start-up time field.
    logic [1:0]    tth;       // Tracking time field.
    logic          ext;       // Channel select extension.
    logic [4:0]    chan;      // Channel select low.
    logic [1:0]    refsel;    // Reference select field.
    logic          ladj;      // Left adjust select.
    logic [9:0]    result;    // Latest coded result.
    logic [9:0]    shadow;    // Copy taken when the low byte is read.
    logic          stat;      // Sticky conversion done flag.
    logic          mask;      // Interrupt mask.
    logic [7:0]    trk_len;   // Length of the current switch closure.
    logic [7:0]    gain_len;  // Length of the current gain sample.
  } adcfmt_regs_t;

  adcfmt_regs_t s_r;   // Registered state.
  adcfmt_regs_t s_nxt; // Next state.

  logic [1:0] ok_sync;    // Synchronised supply and reference ready.
  logic       tick;       // One conversion clock period elapsed.
  logic [6:0] div_m1;     // Prescaler terminal count.
  logic [7:0] sut_ticks;  // Start-up length in conversion clocks.
  logic       diff_mode;  // Selected channel is differential.
  logic [9:0] code;       // Coded value of the current measurement.
  logic [15:0] adj_res;   // Result after alignment.
  logic [15:0] adj_shd;   // Shadow after alignment.
  logic [7:0] rdata;      // Read mux output.
  logic       req;        // New bus request this cycle.
  logic       wr;         // Write takes effect at this edge.
  logic [7:0] wd;         // Write data byte.
  logic       start_set;  // Software asks for a conversion.
  logic       load;       // Result loaded at this edge.

  // ************************************************************
  // Input synchronisation.
  // ************************************************************
  // Both ready flags come from the analog domain.
  adcfmt_sync2 #(
    .W (2)
  ) u_ok_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({analog_supply_ok_i, reference_ok_i}),
    .q_o   (ok_sync)
  );

  // ************************************************************
  // Derived values.
  // ************************************************************
  // Prescaler, coding and read alignment.
  always_comb begin
    // Field values 0 and 1 both give the smallest divider of 2.
    if (s_r.presc == 3'h0) begin
      div_m1 = 7'h01;
    end else begin
      div_m1 = 7'((8'h01 << s_r.presc) - 8'h01);
    end
    tick = (s_r.pre_cnt == div_m1);
    // Four conversion clocks per start-up unit, never less than one.
    sut_ticks = 8'({3'h0, s_r.sut} << ADCFMT_SUT_SHIFT);
    if (sut_ticks == 8'h00) begin
      sut_ticks = 8'h01;
    end
    diff_mode = s_r.ext | (s_r.chan >= ADCFMT_DIFF_CH);
    if (diff_mode) begin
      // Two's complement, clamped at both ends of the range.
      if (meas_i > 12'sd511) begin
        code = 10'h1ff;
      end else if (meas_i < -12'sd512) begin
        code = 10'h200;
      end else begin
        code = meas_i[9:0];
      end
    end else begin
      // Unsigned, negative inputs read as ground.
      if (meas_i > 12'sd1023) begin
        code = 10'h3ff;
      end else if (meas_i < 12'sd0) begin
        code = 10'h000;
      end else begin
        code = meas_i[9:0];
      end
    end
    if (s_r.ladj) begin
      adj_res = {s_r.result, 6'h00};
      adj_shd = {s_r.shadow, 6'h00};
    end else begin
      adj_res = {6'h00, s_r.result};
      adj_shd = {6'h00, s_r.shadow};
    end
  end

  // ************************************************************
  // Register read mux.
  // ************************************************************
  // The high byte comes from the shadow so a conversion that ends
  // between the two reads cannot mix two results.
  always_comb begin
    if (wb_adr_i[4:0] == ADCFMT_OFS_CTRL_A) begin
      rdata = {s_r.enable, s_r.start, 3'h0, s_r.presc};
    end else if (wb_adr_i[4:0] == ADCFMT_OFS_CTRL_B) begin
      rdata = {ok_sync[1], 1'b0, ok_sync[0], 1'b0, s_r.ext, 3'h0};
    end else if (wb_adr_i[4:0] == ADCFMT_OFS_CTRL_C) begin
      rdata = {1'b0, s_r.sut, s_r.tth};
    end else if (wb_adr_i[4:0] == ADCFMT_OFS_CHREF) begin
      rdata = {s_r.refsel, s_r.ladj, s_r.chan};
    end else if (wb_adr_i[4:0] == ADCFMT_OFS_RES_LO) begin
      rdata = adj_res[7:0];
    end else if (wb_adr_i[4:0] == ADCFMT_OFS_RES_HI) begin
      rdata = adj_shd[15:8];
    end else if (wb_adr_i[4:0] == ADCFMT_OFS_IRQ_ST) begin
      rdata = {7'h00, s_r.stat};
    end else if (wb_adr_i[4:0] == ADCFMT_OFS_IRQ_MSK) begin
      rdata = {7'h00, s_r.mask};
    end else begin
      rdata = 8'h00; // Unmapped addresses read zero and still ack.
    end
  end

  // ************************************************************
  // Next-state logic.
  // ************************************************************
  always_comb begin
    s_nxt = s_r;
    req   = wb_cyc_i & wb_stb_i & ~s_r.ack;
    wr    = s_r.ack & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
    wd    = wb_dat_i[7:0];
    start_set = wr & (wb_adr_i[4:0] == ADCFMT_OFS_CTRL_A) &
                wd[ADCFMT_CA_START] & wd[ADCFMT_CA_EN];
    load  = 1'b0;
    // Bus answer one cycle after the request, data with it.
    s_nxt.ack = req;
    if (req) begin
      s_nxt.dat = {24'h000000, rdata};
      if (~wb_we_i && (wb_adr_i[4:0] == ADCFMT_OFS_RES_LO)) begin
        s_nxt.shadow = s_r.result;
      end
    end
    // Free-running prescaler and secondary clock.
    s_nxt.pre_cnt = tick ? 7'h00 : 7'(s_r.pre_cnt + 7'h01);
    if (tick) begin
      s_nxt.sec_clk = ~s_r.sec_clk;
    end
    // Register writes at the edge where the master sees ack.
    if (wr) begin
      if (wb_adr_i[4:0] == ADCFMT_OFS_CTRL_A) begin
        s_nxt.enable = wd[ADCFMT_CA_EN];
        s_nxt.presc  = wd[ADCFMT_CA_PRE_LSB +: 3];
        if (start_set) begin
          s_nxt.start = 1'b1;
        end
      end else if (wb_adr_i[4:0] == ADCFMT_OFS_CTRL_B) begin
        s_nxt.ext = wd[ADCFMT_CB_EXT];
      end else if (wb_adr_i[4:0] == ADCFMT_OFS_CTRL_C) begin
        s_nxt.sut = wd[ADCFMT_CC_SUT_LSB +: 5];
        s_nxt.tth = wd[ADCFMT_CC_TTH_LSB +: 2];
      end else if (wb_adr_i[4:0] == ADCFMT_OFS_CHREF) begin
        s_nxt.refsel = wd[ADCFMT_CR_REF_LSB +: 2];
        s_nxt.ladj   = wd[ADCFMT_CR_LADJ];
        s_nxt.chan   = wd[ADCFMT_CR_CH_LSB +: 5];
      end else if (wb_adr_i[4:0] == ADCFMT_OFS_IRQ_ST) begin
        if (wd[ADCFMT_ST_DONE]) begin
          s_nxt.stat = 1'b0;
        end
      end else if (wb_adr_i[4:0] == ADCFMT_OFS_IRQ_MSK) begin
        s_nxt.mask = wd[ADCFMT_ST_DONE];
      end
    end
    // Conversion sequencer.
    case (s_r.state)
      ADCFMT_OFF: begin
        if (s_nxt.enable) begin
          s_nxt.state    = ADCFMT_STARTUP;
          s_nxt.tick_cnt = 8'h00;
        end
      end
      ADCFMT_STARTUP: begin
        if (tick) begin
          s_nxt.tick_cnt = 8'(s_r.tick_cnt + 8'h01);
          if (8'(s_r.tick_cnt + 8'h01) >= sut_ticks) begin
            s_nxt.state = ADCFMT_READY;
          end
        end
      end
      ADCFMT_READY: begin
        // A pending start simply waits here for both ready flags.
        if (s_r.start && (ok_sync == 2'b11)) begin
          s_nxt.state     = ADCFMT_TRACK;
          s_nxt.pre_cnt   = 7'h00; // Align the clock to the phase.
          s_nxt.sec_clk   = 1'b1;
          s_nxt.tick_cnt  = 8'h00;
          s_nxt.min_cnt   = 8'h00;
          s_nxt.sample_sw = ~diff_mode;
          s_nxt.gain_s    = diff_mode;
        end
      end
      ADCFMT_TRACK: begin
        if (s_r.min_cnt != 8'hff) begin
          s_nxt.min_cnt = 8'(s_r.min_cnt + 8'h01);
        end
        if (tick) begin
          s_nxt.tick_cnt = 8'(s_r.tick_cnt + 8'h01);
        end
        if (s_r.gain_s) begin
          // Gain stage samples for one high half of the clock.
          if (tick) begin
            s_nxt.gain_s   = 1'b0;
            s_nxt.state    = ADCFMT_CONVERT;
            s_nxt.tick_cnt = 8'h00;
          end
        end else if ((s_r.min_cnt >= 8'(ADCFMT_MIN_TRACK - 8'h01)) &&
                     (s_nxt.tick_cnt >= 8'({6'h00, s_r.tth} + 8'h01))) begin
          s_nxt.sample_sw = 1'b0;
          s_nxt.state     = ADCFMT_CONVERT;
          s_nxt.tick_cnt  = 8'h00;
        end
      end
      ADCFMT_CONVERT: begin
        if (tick) begin
          s_nxt.tick_cnt = 8'(s_r.tick_cnt + 8'h01);
          if (s_r.tick_cnt == 8'(ADCFMT_CONV_TICKS - 8'h01)) begin
            load         = 1'b1;
            s_nxt.state  = ADCFMT_READY;
            s_nxt.result = code;
            s_nxt.start  = start_set;
          end
        end
      end
      default: begin
        s_nxt.state = ADCFMT_OFF;
      end
    endcase
    // The done flag is set after any clear so an event is never lost.
    if (load) begin
      s_nxt.stat = 1'b1;
    end
    // Disabling aborts everything and drops a pending start.
    if (!s_nxt.enable) begin
      s_nxt.state     = ADCFMT_OFF;
      s_nxt.start     = 1'b0;
      s_nxt.sample_sw = 1'b0;
      s_nxt.gain_s    = 1'b0;
    end
    s_nxt.irq = s_nxt.stat & s_nxt.mask;
    // Closure lengths, watched by the checks below.
    s_nxt.trk_len  = s_nxt.sample_sw ? 8'(s_r.trk_len + 8'h01) : 8'h00;
    s_nxt.gain_len = s_nxt.gain_s ? 8'(s_r.gain_len + 8'h01) : 8'h00;
  end

  // ************************************************************
  // State register.
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r        <= '0;
      s_r.state  <= ADCFMT_OFF;
      s_r.presc  <= ADCFMT_RST_PRE;
      s_r.sut    <= ADCFMT_RST_SUT;
      s_r.tth    <= ADCFMT_RST_TTH;
      s_r.refsel <= ADCFMT_RST_REF;
      s_r.chan   <= ADCFMT_RST_CH;
      s_r.mask   <= ADCFMT_RST_MASK;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o                 = s_r.dat;
  assign wb_ack_o                 = s_r.ack;
  assign converter_enable_o       = s_r.enable;
  assign sample_switch_o          = s_r.sample_sw;
  assign gain_sample_o            = s_r.gain_s;
  assign secondary_conv_clock_o   = s_r.sec_clk;
  assign reference_select_field_o = s_r.refsel;
  assign channel_o                = {s_r.ext, s_r.chan};
  assign irq_o                    = s_r.irq;

  // ************************************************************
  // Checks.
  // ************************************************************
  min_track_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(s_r.sample_sw) && s_r.enable |-> $past(s_r.trk_len) >= ADCFMT_MIN_TRACK)
    else $error("sampling switch opened too early");
  // The tick count of the closing cycle is rebuilt from the registered count, because the
  // next-state copy is already cleared for the conversion phase in that same cycle.
  track_ext_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(s_r.sample_sw) && s_r.enable |->
      s_r.state == ADCFMT_CONVERT &&
      8'($past(s_r.tick_cnt) + {7'h00, $past(tick)}) > {6'h00, $past(s_r.tth)})
    else $error("tracking shorter than the tracking field asks");
  gain_half_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(s_r.gain_s) && s_r.enable |-> $past(s_r.gain_len) == {1'b0, div_m1} + 8'h01)
    else $error("gain sample not half a secondary period");
  done_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    load |=> s_r.stat && s_r.result == $past(code) && s_r.state == ADCFMT_READY)
    else $error("completion did not flag and load the result");
  se_sat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    load && !diff_mode && meas_i > 12'sd1023 |=> s_r.result == 10'h3ff)
    else $error("single-ended overrange not saturated");
  diff_sat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    load && diff_mode && meas_i < -12'sd512 |=> s_r.result == 10'h200)
    else $error("differential underrange not saturated");
  sign_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    load && diff_mode |=> s_r.result[9] == $past(meas_i < 12'sd0))
    else $error("sign bit wrong");
  right_adj_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && wb_adr_i[4:0] == ADCFMT_OFS_RES_LO && !s_r.ladj
      |=> s_r.dat[7:0] == $past(s_r.result[7:0]))
    else $error("right aligned low byte wrong");
  gate_ok_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.state == ADCFMT_TRACK && $past(s_r.state) == ADCFMT_READY |->
      $past(ok_sync) == 2'b11 && $past(s_r.start))
    else $error("conversion started without ready flags");
  start_busy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.state == ADCFMT_TRACK || s_r.state == ADCFMT_CONVERT |-> s_r.start)
    else $error("start bit clear while busy");
  presc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.presc == 3'h4 |-> div_m1 == 7'h0f)
    else $error("prescaler divide wrong");

endmodule : adcfmt_top
